// file: rtl/nvr_pkg.sv
/*
  Shared constants for the nonvolatile memory and clock bus port.
  Assumes a 40 MHz system clock and a byte-wide asynchronous host bus.
*/
package nvr_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 25;
  localparam longint SECOND_NS = 1000000000;
  localparam int SEC_CYC = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam longint WD_UNIT_NS = 62500000;
  localparam int WD_UNIT_CYC = int'(WD_UNIT_NS / CLK_PERIOD_NS);
  localparam logic [3:0] REG_FLAGS = 4'h0;
  localparam logic [3:0] REG_ASEC = 4'h2;
  localparam logic [3:0] REG_AMIN = 4'h3;
  localparam logic [3:0] REG_AHOUR = 4'h4;
  localparam logic [3:0] REG_ADATE = 4'h5;
  localparam logic [3:0] REG_INTR = 4'h6;
  localparam logic [3:0] REG_WDOG = 4'h7;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_SEC = 4'h9;
  localparam int CTRL_W_BIT = 7;
  localparam int CTRL_R_BIT = 6;
  localparam int OSC_BIT = 7;
  localparam int AM_BIT = 7;
  localparam int AE_BIT = 7;
  localparam int ABE_BIT = 5;
  localparam int WDS_BIT = 7;
  localparam int WD_BMB_HI = 6;
  localparam int WD_BMB_LO = 2;
  localparam int WD_RB_HI = 1;
  localparam int WD_RB_LO = 0;
  localparam int WF_BIT = 7;
  localparam int AF_BIT = 6;
  localparam int BATTERY_LOW_FLAG_BIT = 4;
  localparam int FI_CENT = 0;
  localparam int FI_SEC = 1;
  localparam int FI_MIN = 2;
  localparam int FI_HOUR = 3;
  localparam int FI_DAY = 4;
  localparam int FI_DATE = 5;
  localparam int FI_MONTH = 6;
  localparam int FI_YEAR = 7;
  localparam logic [7:0] FIELD_MASK [8] = '{8'h3f, 8'h7f, 8'h7f, 8'h3f,
                                           8'h07, 8'h3f, 8'h1f, 8'hff};
  localparam logic [7:0] FIELD_MIN [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                          8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] FIELD_MAX [8] = '{8'h39, 8'h59, 8'h59, 8'h23,
                                          8'h07, 8'h31, 8'h12, 8'h99};
  localparam logic [7:0] REG_RST [16] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                         8'h00, 8'h00, 8'h00, 8'h00,
                                         8'h00, 8'h80, 8'h00, 8'h00,
                                         8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  typedef enum logic [2:0] {
    ACC_IDLE, ACC_MEM_RD, ACC_MEM_WR, ACC_RTC_RD, ACC_RTC_WR, ACC_BAD
  } nvr_acc_t;
endpackage

// file: rtl/nvr_mem_if.sv
/*
  Carrier between the bus port and its byte array.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
interface nvr_mem_if #(parameter int AW = 20, parameter int DW = 8);
  logic [AW-1:0] addr;
  logic we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

// file: rtl/nvr_sram.sv
/*
  Static byte array behind the bus port, one byte per access.
  Assumes the port holds the address for a cycle to read back its byte.
*/
`timescale 1ns/1ps
module nvr_sram #(
  parameter int AW = 20,
  parameter int DW = 8
) (
  input wire logic clk_in,
  nvr_mem_if.mem mem_bus
);
  logic [DW-1:0] mem_r [2**AW];
  logic [DW-1:0] rdata_r;

  always_ff @(posedge clk_in) begin
    if (mem_bus.we) begin
      mem_r[mem_bus.addr] <= mem_bus.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_r <= mem_r[mem_bus.addr];
  end

  assign mem_bus.rdata = rdata_r;
endmodule

// file: rtl/nvr_bcd_cnt.sv
/*
  One packed BCD time field that counts up and wraps to its least value.
  Assumes the caller chains the wrap output into the next field.
*/
`timescale 1ns/1ps
module nvr_bcd_cnt #(
  parameter logic [7:0] MINV = 8'h00,
  parameter logic [7:0] RSTV = 8'h00
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [7:0] load_val_in,
  input wire logic inc_in,
  input wire logic [7:0] max_in,
  output logic [7:0] val_out,
  output logic wrap_out
);
  logic [7:0] val_r;
  logic [7:0] val_nxt;

  // A value above the limit, such as day 31 in a short month, also wraps.
  assign wrap_out = inc_in && (val_r >= max_in);

  always_comb begin
    val_nxt = val_r;
    if (load_in) begin
      val_nxt = load_val_in;
    end else if (wrap_out) begin
      val_nxt = MINV;
    end else if (inc_in) begin
      if (val_r[3:0] == nvr_pkg::BCD_DIGIT_MAX) begin
        val_nxt = {val_r[7:4] + 4'h1, 4'h0};
      end else begin
        val_nxt = {val_r[7:4], val_r[3:0] + 4'h1};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      val_r <= RSTV;
    end else begin
      val_r <= val_nxt;
    end
  end

  assign val_out = val_r;
endmodule

// file: rtl/nvr_top.sv
/*
  Byte-wide host port of a battery-backed memory with a real-time clock.
  Assumes host strobes are synchronous to mclk_in and never select both parts.
*/
// Functional notes
// RULE1 - One million byte static array, byte bus.
// RULE2 - Supply failure: backup source, block writes.
// RULE3 - Time fields kept as packed BCD, 24-hour.
// RULE4 - Month lengths and leap years automatic.
// RULE5 - Bus reaches only visible time copy.
// RULE6 - Internal time counts while visible copy frozen.
// RULE7 - Alarm match drives interrupt low.
// RULE8 - Alarm on battery only when enabled.
// RULE9 - Missed watchdog service raises interrupt.
// RULE10 - Reset output held during supply failure.
// RULE11 - Battery low flag read-only, reflects cell.
// RULE12 - Memory read: clock select, write high. Code decodes memory select, write high.
// RULE13 - All twenty address bits pick byte.
// RULE14 - Memory write: memory select, write low.
// RULE15 - Write starts at later falling edge.
// RULE16 - Write ends at earlier rising edge.
// RULE17 - Host keeps address stable during write.
// RULE18 - Host observes write recovery before next.
// RULE19 - Host keeps other select, output enable high.
// RULE20 - Falling write enable turns drivers off.
// RULE21 - Clock read uses low four address bits.
// RULE22 - Clock write framed by select, write.
// RULE23 - Drive only on read with enable.
// RULE24 - Host never asserts both selects together.
`timescale 1ns/1ps
module nvr_top #(
  parameter int unsigned TICK_CYC = nvr_pkg::SEC_CYC,
  parameter int unsigned WD_UNIT_CYC = nvr_pkg::WD_UNIT_CYC,
  parameter int AW = nvr_pkg::ADDR_W
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic mem_sel_n_in,
  input wire logic clk_sel_n_in,
  input wire logic write_en_n_in,
  input wire logic out_en_n_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  input wire logic supply_fail_in,
  input wire logic battery_low_in,
  output logic on_battery_out,
  output logic intr_freqtest_n_out,
  output logic intr_freqtest_oe_n_out,
  output logic reset_n_out,
  output logic reset_oe_n_out
);
  logic rst_meta_r;
  logic rst_n_r;
  nvr_pkg::nvr_acc_t acc;
  nvr_pkg::nvr_acc_t acc_r;
  logic [AW-1:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic wr_blk_r;
  logic mem_commit;
  logic rtc_commit;
  logic [7:0] vis_r [16];
  logic wf_r;
  logic af_r;
  logic [3:0] rd_idx_r;
  logic flags_rd_end;
  logic [7:0] rtc_mux;
  logic [7:0] rtc_q_r;
  logic [7:0] data_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic tick_d_r;
  logic osc_on;
  logic w_prev_r;
  logic w_fall;
  logic freeze;
  logic [7:0] cnt [8];
  logic [7:0] maxv [8];
  logic [7:0] inc;
  logic [7:0] wrap;
  logic alarm_hit;
  logic [31:0] wd_pre_r;
  logic [10:0] wd_cnt_r;
  logic wd_svc;
  logic wd_unit;
  logic wd_expire;
  logic irq_r;
  logic rst_drive_r;
  logic bat_r;

  nvr_mem_if #(.AW(AW), .DW(nvr_pkg::DATA_W)) mem_bus ();

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_r <= 1'h0;
      rst_n_r <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_n_r <= rst_meta_r;
    end
  end

  // RULE24 both selects invalid.
  always_comb begin
    acc = nvr_pkg::ACC_IDLE;
    if (!clk_sel_n_in && !mem_sel_n_in) begin
      acc = nvr_pkg::ACC_BAD;
    end else if (!mem_sel_n_in) begin
      // RULE12 memory read decode.
      acc = write_en_n_in ? nvr_pkg::ACC_MEM_RD : nvr_pkg::ACC_MEM_WR;
    end else if (!clk_sel_n_in) begin
      // RULE21 clock read decode.
      acc = write_en_n_in ? nvr_pkg::ACC_RTC_RD : nvr_pkg::ACC_RTC_WR;
    end
  end

  // RULE14 capture while active. The last sampled data wins, so data may settle late.
  always_ff @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      acc_r <= nvr_pkg::ACC_IDLE;
      wr_addr_r <= '0;
      wr_data_r <= 8'h00;
      wr_blk_r <= 1'h0;
      rd_idx_r <= 4'h0;
    end else begin
      acc_r <= acc;
      if (acc == nvr_pkg::ACC_MEM_WR || acc == nvr_pkg::ACC_RTC_WR) begin
        wr_addr_r <= addr_in;
        wr_data_r <= data_in;
        wr_blk_r <= wr_blk_r || supply_fail_in;
      end else begin
        wr_blk_r <= 1'h0;
      end
      if (acc == nvr_pkg::ACC_RTC_RD) begin
        rd_idx_r <= addr_in[3:0];
      end
    end
  end

  // RULE15 starts at later fall.
  // RULE16 commits at earlier rise.
  // RULE2 write blocking.
  assign mem_commit = acc_r == nvr_pkg::ACC_MEM_WR && acc != nvr_pkg::ACC_MEM_WR &&
                      !wr_blk_r && !supply_fail_in;
  // RULE22 clock write framing.
  assign rtc_commit = acc_r == nvr_pkg::ACC_RTC_WR && acc != nvr_pkg::ACC_RTC_WR &&
                      !wr_blk_r && !supply_fail_in;

  // RULE13 full address used.
  assign mem_bus.addr = mem_commit ? wr_addr_r : addr_in;
  assign mem_bus.we = mem_commit;
  assign mem_bus.wdata = wr_data_r;

  // RULE1 byte array.
  nvr_sram #(.AW(AW), .DW(nvr_pkg::DATA_W)) u_sram (
    .clk_in(mclk_in),
    .mem_bus(mem_bus)
  );

  // RULE6 free-running seconds.
  assign osc_on = !vis_r[nvr_pkg::REG_SEC][nvr_pkg::OSC_BIT];
  assign tick = osc_on && (tick_cnt_r == 32'(TICK_CYC - 1));

  always_ff @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_cnt_r <= 32'h0;
      tick_d_r <= 1'h0;
    end else begin
      tick_cnt_r <= (!osc_on || tick) ? 32'h0 : tick_cnt_r + 32'h1;
      tick_d_r <= tick;
    end
  end

  function automatic logic div4_bcd(input logic [7:0] v);
    if (v[4]) begin
      div4_bcd = (v[3:0] == 4'h2) || (v[3:0] == 4'h6);
    end else begin
      div4_bcd = (v[3:0] == 4'h0) || (v[3:0] == 4'h4) || (v[3:0] == 4'h8);
    end
  endfunction

  // RULE4 month length, leap year.
  function automatic logic [7:0] dim_f(input logic [7:0] mon, input logic [7:0] yr,
                                       input logic [7:0] cen);
    logic leap;
    leap = div4_bcd(yr) && (yr != 8'h00 || div4_bcd(cen));
    case (mon)
      nvr_pkg::MON_FEB: dim_f = leap ? nvr_pkg::DAYS_29 : nvr_pkg::DAYS_28;
      nvr_pkg::MON_APR, nvr_pkg::MON_JUN, nvr_pkg::MON_SEP,
      nvr_pkg::MON_NOV: dim_f = nvr_pkg::DAYS_30;
      default: dim_f = nvr_pkg::DAYS_31;
    endcase
  endfunction

  always_comb begin
    inc = 8'h00;
    inc[nvr_pkg::FI_SEC] = tick;
    inc[nvr_pkg::FI_MIN] = wrap[nvr_pkg::FI_SEC];
    inc[nvr_pkg::FI_HOUR] = wrap[nvr_pkg::FI_MIN];
    inc[nvr_pkg::FI_DAY] = wrap[nvr_pkg::FI_HOUR];
    inc[nvr_pkg::FI_DATE] = wrap[nvr_pkg::FI_HOUR];
    inc[nvr_pkg::FI_MONTH] = wrap[nvr_pkg::FI_DATE];
    inc[nvr_pkg::FI_YEAR] = wrap[nvr_pkg::FI_MONTH];
    inc[nvr_pkg::FI_CENT] = wrap[nvr_pkg::FI_YEAR];
    for (int i = 0; i < 8; i++) begin
      maxv[i] = nvr_pkg::FIELD_MAX[i];
    end
    maxv[nvr_pkg::FI_DATE] = dim_f(cnt[nvr_pkg::FI_MONTH], cnt[nvr_pkg::FI_YEAR],
                                   cnt[nvr_pkg::FI_CENT]);
  end

  assign w_fall = w_prev_r && !vis_r[nvr_pkg::REG_CTRL][nvr_pkg::CTRL_W_BIT];

  // RULE3 packed BCD fields.
  for (genvar g = 0; g < 8; g++) begin : g_field
    nvr_bcd_cnt #(
      .MINV(nvr_pkg::FIELD_MIN[g]),
      .RSTV(nvr_pkg::REG_RST[g + 8] & nvr_pkg::FIELD_MASK[g])
    ) u_cnt (
      .clk_in(mclk_in),
      .rst_n_in(rst_n_r),
      .load_in(w_fall),
      .load_val_in(vis_r[g + 8] & nvr_pkg::FIELD_MASK[g]),
      .inc_in(inc[g]),
      .max_in(maxv[g]),
      .val_out(cnt[g]),
      .wrap_out(wrap[g])
    );
  end

  // The cycle after the write bit drops still holds, so the load is not overwritten.
  assign freeze = vis_r[nvr_pkg::REG_CTRL][nvr_pkg::CTRL_W_BIT] || w_prev_r ||
                  vis_r[nvr_pkg::REG_CTRL][nvr_pkg::CTRL_R_BIT];

  // RULE5 bus sees visible copy.
  always_ff @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int k = 0; k < 16; k++) begin
        vis_r[k] <= nvr_pkg::REG_RST[k];
      end
      w_prev_r <= 1'h0;
    end else begin
      w_prev_r <= vis_r[nvr_pkg::REG_CTRL][nvr_pkg::CTRL_W_BIT];
      if (!freeze) begin
        for (int i = 0; i < 8; i++) begin
          vis_r[i + 8] <= (vis_r[i + 8] & ~nvr_pkg::FIELD_MASK[i]) | cnt[i];
        end
      end
      // RULE11 flags not writable.
      if (rtc_commit && wr_addr_r[3:0] != nvr_pkg::REG_FLAGS) begin
        vis_r[wr_addr_r[3:0]] <= wr_data_r;
      end
    end
  end

  function automatic logic am_hit(input logic [7:0] al, input logic [7:0] cur,
                                  input logic [7:0] msk);
    am_hit = al[nvr_pkg::AM_BIT] || ((al & msk) == (cur & msk));
  endfunction

  // RULE7 alarm compare.
  assign alarm_hit =
    am_hit(vis_r[nvr_pkg::REG_ASEC], cnt[nvr_pkg::FI_SEC], nvr_pkg::FIELD_MASK[nvr_pkg::FI_SEC]) &&
    am_hit(vis_r[nvr_pkg::REG_AMIN], cnt[nvr_pkg::FI_MIN], nvr_pkg::FIELD_MASK[nvr_pkg::FI_MIN]) &&
    am_hit(vis_r[nvr_pkg::REG_AHOUR], cnt[nvr_pkg::FI_HOUR],
           nvr_pkg::FIELD_MASK[nvr_pkg::FI_HOUR]) &&
    am_hit(vis_r[nvr_pkg::REG_ADATE], cnt[nvr_pkg::FI_DATE],
           nvr_pkg::FIELD_MASK[nvr_pkg::FI_DATE]);

  // RULE9 watchdog interval.
  assign wd_svc = rtc_commit && wr_addr_r[3:0] == nvr_pkg::REG_WDOG;
  assign wd_unit = wd_cnt_r != 11'h0 && wd_pre_r == 32'(WD_UNIT_CYC - 1);
  assign wd_expire = wd_unit && wd_cnt_r == 11'h1;

  always_ff @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wd_pre_r <= 32'h0;
      wd_cnt_r <= 11'h0;
    end else begin
      wd_pre_r <= (wd_svc || wd_unit || wd_cnt_r == 11'h0) ? 32'h0 : wd_pre_r + 32'h1;
      if (wd_svc) begin
        wd_cnt_r <= 11'({6'h00, wr_data_r[nvr_pkg::WD_BMB_HI:nvr_pkg::WD_BMB_LO]}) <<
                    {wr_data_r[nvr_pkg::WD_RB_HI:nvr_pkg::WD_RB_LO], 1'h0};
      end else if (wd_unit) begin
        wd_cnt_r <= wd_cnt_r - 11'h1;
      end
    end
  end

  // Flags clear when a read of them ends, so the whole read sees the set value.
  assign flags_rd_end = acc_r == nvr_pkg::ACC_RTC_RD && acc != nvr_pkg::ACC_RTC_RD &&
                        rd_idx_r == nvr_pkg::REG_FLAGS;

  always_ff @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      af_r <= 1'h0;
      wf_r <= 1'h0;
    end else begin
      af_r <= (tick_d_r && alarm_hit) || (af_r && !flags_rd_end);
      wf_r <= wd_expire || (wf_r && !flags_rd_end);
    end
  end

  // RULE11 battery low visible.
  always_comb begin
    rtc_mux = vis_r[addr_in[3:0]];
    if (addr_in[3:0] == nvr_pkg::REG_FLAGS) begin
      rtc_mux = 8'h00;
      rtc_mux[nvr_pkg::WF_BIT] = wf_r;
      rtc_mux[nvr_pkg::AF_BIT] = af_r;
      rtc_mux[nvr_pkg::BATTERY_LOW_FLAG_BIT] = battery_low_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rtc_q_r <= 8'h00;
      data_r <= 8'h00;
    end else begin
      rtc_q_r <= rtc_mux;
      data_r <= (acc == nvr_pkg::ACC_MEM_RD) ? mem_bus.rdata : rtc_q_r;
    end
  end

  assign data_out = data_r;
  // RULE20 write enable disables.
  // RULE23 drive only on read.
  assign data_oe_n_out = !((acc == nvr_pkg::ACC_MEM_RD || acc == nvr_pkg::ACC_RTC_RD) &&
                           !out_en_n_in);

  // RULE8 backup alarm gating.
  always_ff @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= (af_r && vis_r[nvr_pkg::REG_INTR][nvr_pkg::AE_BIT] &&
                (!supply_fail_in || vis_r[nvr_pkg::REG_INTR][nvr_pkg::ABE_BIT])) ||
               (wf_r && !vis_r[nvr_pkg::REG_WDOG][nvr_pkg::WDS_BIT]);
    end
  end

  // RULE10 reset during failure. Reset is held low out of power-on too.
  always_ff @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rst_drive_r <= 1'h1;
      bat_r <= 1'h0;
    end else begin
      rst_drive_r <= supply_fail_in;
      bat_r <= supply_fail_in;
    end
  end

  assign intr_freqtest_n_out = 1'h0;
  assign intr_freqtest_oe_n_out = !irq_r;
  assign reset_n_out = 1'h0;
  assign reset_oe_n_out = !rst_drive_r;
  assign on_battery_out = bat_r;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_r);

  property p_no_wr_fail;
    supply_fail_in |-> !mem_bus.we;
  endproperty
  a_no_wr_fail: assert property (p_no_wr_fail) else $error("write during fail"); // RULE2

  property p_no_early_wr;
    acc == nvr_pkg::ACC_MEM_WR |-> !mem_bus.we;
  endproperty
  a_no_early_wr: assert property (p_no_early_wr) else $error("early write"); // RULE15

  sequence s_mem_wr;
    acc != nvr_pkg::ACC_MEM_WR ##1 (acc == nvr_pkg::ACC_MEM_WR && !supply_fail_in) [*2]
    ##1 (acc != nvr_pkg::ACC_MEM_WR && !supply_fail_in);
  endsequence
  property p_wr_commit;
    s_mem_wr |-> mem_bus.we && mem_bus.addr == $past(addr_in);
  endproperty
  a_wr_commit: assert property (p_wr_commit) else $error("write not committed"); // RULE16

  property p_we_hiz;
    !write_en_n_in |-> data_oe_n_out;
  endproperty
  a_we_hiz: assert property (p_we_hiz) else $error("drive during write"); // RULE20

  property p_standby;
    clk_sel_n_in && mem_sel_n_in |-> data_oe_n_out;
  endproperty
  a_standby: assert property (p_standby) else $error("drive in standby"); // RULE23

  property p_mem_rd;
    (acc == nvr_pkg::ACC_MEM_RD) [*2] |-> data_out == $past(mem_bus.rdata);
  endproperty
  a_mem_rd: assert property (p_mem_rd) else $error("bad read data"); // RULE12

  property p_rst_out;
    supply_fail_in |=> !reset_oe_n_out;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset not held"); // RULE10

  property p_blf;
    (acc == nvr_pkg::ACC_RTC_RD && addr_in[3:0] == nvr_pkg::REG_FLAGS) [*3] |->
      data_out[nvr_pkg::BATTERY_LOW_FLAG_BIT] == $past(battery_low_in, 2);
  endproperty
  a_blf: assert property (p_blf) else $error("battery flag wrong"); // RULE11

  property p_int_count;
    tick && !w_fall |=> cnt[nvr_pkg::FI_SEC] != $past(cnt[nvr_pkg::FI_SEC]);
  endproperty
  a_int_count: assert property (p_int_count) else $error("seconds stalled"); // RULE6

  sequence s_alarm;
    (tick_d_r && alarm_hit && !supply_fail_in) ##1
      (vis_r[nvr_pkg::REG_INTR][nvr_pkg::AE_BIT] && !supply_fail_in);
  endsequence
  property p_alarm_irq;
    s_alarm |=> !intr_freqtest_oe_n_out;
  endproperty
  a_alarm_irq: assert property (p_alarm_irq) else $error("alarm missed"); // RULE7

  property p_bkup_alarm;
    supply_fail_in && !vis_r[nvr_pkg::REG_INTR][nvr_pkg::ABE_BIT] &&
      (!wf_r || vis_r[nvr_pkg::REG_WDOG][nvr_pkg::WDS_BIT]) |=> intr_freqtest_oe_n_out;
  endproperty
  a_bkup_alarm: assert property (p_bkup_alarm) else $error("alarm on battery"); // RULE8

  property p_wd_irq;
    wd_expire ##1 !vis_r[nvr_pkg::REG_WDOG][nvr_pkg::WDS_BIT] |=> !intr_freqtest_oe_n_out;
  endproperty
  a_wd_irq: assert property (p_wd_irq) else $error("watchdog missed"); // RULE9
endmodule

// file: testbench/nvr_host_model.sv
/* Bus master model that drives the host strobes of the memory port.
   Assumes one clock and strobe changes only at its falling edge. */
`timescale 1ns/1ps
module nvr_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic oe_n_seen_in,
  output logic mem_sel_n_out,
  output logic clk_sel_n_out,
  output logic write_en_n_out,
  output logic out_en_n_out,
  output logic [19:0] addr_out,
  output logic [7:0] data_out
);
  initial begin
    mem_sel_n_out = 1'b1;
    clk_sel_n_out = 1'b1;
    write_en_n_out = 1'b1;
    out_en_n_out = 1'b1;
    addr_out = 20'h00000;
    data_out = 8'h00;
  end

  task automatic sel(input logic rtc);
    if (rtc) begin
      clk_sel_n_out = 1'b0;
    end else begin
      mem_sel_n_out = 1'b0;
    end
  endtask

  task automatic idle();
    mem_sel_n_out = 1'b1;
    clk_sel_n_out = 1'b1;
    out_en_n_out = 1'b1;
    data_out = ~data_out;
    @(negedge clk_in);
  endtask

  task automatic wr(input logic rtc, input logic [19:0] a, input logic [7:0] d,
                    input logic oe, output logic oe_n);
    @(negedge clk_in);
    addr_out = a;
    data_out = d;
    out_en_n_out = oe;
    sel(rtc);
    if (!oe) begin
      @(negedge clk_in);
    end
    write_en_n_out = 1'b0;
    @(negedge clk_in);
    oe_n = oe_n_seen_in;
    @(negedge clk_in);
    write_en_n_out = 1'b1;
    @(negedge clk_in);
    idle();
  endtask

  task automatic rd(input logic rtc, input logic [19:0] a, input logic oe,
                    output logic [7:0] d, output logic oe_n);
    @(negedge clk_in);
    addr_out = a;
    out_en_n_out = oe;
    sel(rtc);
    repeat (3) @(negedge clk_in);
    d = rdata_in;
    oe_n = oe_n_seen_in;
    idle();
  endtask
endmodule

// file: testbench/nv_sram_rtc_bus_port_tb_top.sv
/* Self-checking bench for the memory and clock host port.
   Assumes shortened tick and watchdog counts and the host model. */
`timescale 1ns/1ps
module nv_sram_rtc_bus_port_tb_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic supply_fail = 1'b0;
  logic battery_low = 1'b0;
  logic mem_sel_n, clk_sel_n, we_n, oe_n;
  logic [19:0] addr;
  logic [7:0] wdata, rdata;
  logic data_oe_n, on_batt, irq_pin, irq_oe_n, rst_pin, rst_oe_n;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  always #12.5 mclk = ~mclk;

  nvr_top #(.TICK_CYC(20), .WD_UNIT_CYC(4), .AW(20)) dut (
    .mclk_in(mclk), .arst_n_in(arst_n), .mem_sel_n_in(mem_sel_n),
    .clk_sel_n_in(clk_sel_n), .write_en_n_in(we_n), .out_en_n_in(oe_n),
    .addr_in(addr), .data_in(wdata), .data_out(rdata), .data_oe_n_out(data_oe_n),
    .supply_fail_in(supply_fail), .battery_low_in(battery_low),
    .on_battery_out(on_batt), .intr_freqtest_n_out(irq_pin),
    .intr_freqtest_oe_n_out(irq_oe_n), .reset_n_out(rst_pin),
    .reset_oe_n_out(rst_oe_n));

  nvr_host_model host (
    .clk_in(mclk), .rdata_in(rdata), .oe_n_seen_in(data_oe_n),
    .mem_sel_n_out(mem_sel_n), .clk_sel_n_out(clk_sel_n), .write_en_n_out(we_n),
    .out_en_n_out(oe_n), .addr_out(addr), .data_out(wdata));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic t_rtc();
    logic [7:0] d;
    logic o;
    host.rd(1'b1, 20'h00009, 1'b0, d, o);
    check("sec reset", d, 8'h80);
    host.wr(1'b1, 20'hfff03, 8'h45, 1'b1, o);
    host.rd(1'b1, 20'h00003, 1'b0, d, o);
    check("alarm min", d, 8'h45);
    $display("test rtc done");
  endtask

  task automatic t_mem();
    logic [7:0] d;
    logic o;
    host.wr(1'b0, 20'h80005, 8'ha5, 1'b1, o);
    check("wr oe_n", {7'h00, o}, 8'h01);
    host.wr(1'b0, 20'h00005, 8'h3c, 1'b1, o);
    host.rd(1'b0, 20'h80005, 1'b0, d, o);
    check("mem hi", d, 8'ha5);
    check("rd oe_n", {7'h00, o}, 8'h00);
    host.rd(1'b0, 20'h00005, 1'b1, d, o);
    check("mem lo", d, 8'h3c);
    check("rd no oe", {7'h00, o}, 8'h01);
    host.wr(1'b0, 20'h00006, 8'h11, 1'b0, o);
    check("we off drv", {7'h00, o}, 8'h01);
    host.rd(1'b0, 20'h00006, 1'b0, d, o);
    check("mem late wr", d, 8'h11);
    $display("test mem done");
  endtask

  task automatic t_flags();
    logic [7:0] d;
    logic o;
    battery_low = 1'b1;
    host.wr(1'b1, 20'h00000, 8'h00, 1'b1, o);
    host.rd(1'b1, 20'h00000, 1'b0, d, o);
    check("batt low", {7'h00, d[4]}, 8'h01);
    battery_low = 1'b0;
    host.wr(1'b1, 20'h00000, 8'hff, 1'b1, o);
    host.rd(1'b1, 20'h00000, 1'b0, d, o);
    check("batt ok", {7'h00, d[4]}, 8'h00);
    $display("test flags done");
  endtask

  task automatic t_supply();
    logic [7:0] d;
    logic o;
    host.wr(1'b0, 20'h00007, 8'h22, 1'b1, o);
    @(negedge mclk);
    supply_fail = 1'b1;
    repeat (3) @(negedge mclk);
    check("on batt", {7'h00, on_batt}, 8'h01);
    check("rst on", {7'h00, rst_oe_n}, 8'h00);
    check("rst pin", {7'h00, rst_pin}, 8'h00);
    host.wr(1'b0, 20'h00007, 8'h77, 1'b1, o);
    supply_fail = 1'b0;
    repeat (3) @(negedge mclk);
    check("rst off", {7'h00, rst_oe_n}, 8'h01);
    host.rd(1'b0, 20'h00007, 1'b0, d, o);
    check("blocked wr", d, 8'h22);
    $display("test supply done");
  endtask

  task automatic t_alarm();
    logic [7:0] d, s1;
    logic o, low;
    low = 1'b0;
    for (int r = 2; r < 6; r++) begin
      host.wr(1'b1, 20'(r), 8'h80, 1'b1, o);
    end
    host.wr(1'b1, 20'h00006, 8'h80, 1'b1, o);
    host.wr(1'b1, 20'h00008, 8'h80, 1'b1, o);
    host.wr(1'b1, 20'h00009, 8'h00, 1'b1, o);
    host.wr(1'b1, 20'h00008, 8'h00, 1'b1, o);
    supply_fail = 1'b1;
    repeat (60) @(negedge mclk) low |= !irq_oe_n;
    check("irq on batt", {7'h00, low}, 8'h00);
    supply_fail = 1'b0;
    low = 1'b0;
    repeat (30) @(negedge mclk) low |= !irq_oe_n;
    check("irq alarm", {7'h00, low}, 8'h01);
    host.wr(1'b1, 20'h00008, 8'h40, 1'b1, o);
    host.rd(1'b1, 20'h00009, 1'b0, s1, o);
    repeat (50) @(negedge mclk);
    host.rd(1'b1, 20'h00009, 1'b0, d, o);
    check("frozen sec", d, s1);
    host.wr(1'b1, 20'h00008, 8'h00, 1'b1, o);
    host.rd(1'b1, 20'h00009, 1'b0, d, o);
    check("sec ran", {7'h00, d != s1}, 8'h01);
    $display("test alarm done");
  endtask

  task automatic t_wdog();
    logic [7:0] d;
    logic o;
    host.wr(1'b1, 20'h00006, 8'h00, 1'b1, o);
    repeat (2) @(negedge mclk);
    check("irq quiet", {7'h00, irq_oe_n}, 8'h01);
    host.wr(1'b1, 20'h00007, 8'h04, 1'b1, o);
    repeat (10) @(negedge mclk);
    check("irq wdog", {7'h00, irq_oe_n}, 8'h00);
    check("irq pin", {7'h00, irq_pin}, 8'h00);
    host.rd(1'b1, 20'h00000, 1'b0, d, o);
    check("wdog flag", {7'h00, d[7]}, 8'h01);
    $display("test wdog done");
  endtask

  initial begin
    repeat (16) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_rtc();
    t_mem();
    t_flags();
    t_supply();
    t_alarm();
    t_wdog();
    wrap_up();
  end
endmodule
